// ---- core/parity_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

module parity_unit (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire logic tx_phase_in,
    input wire logic rx_phase_in,
    input wire logic gfx_txn_in,
    input wire logic [31:0] ad_in,
    input wire logic [3:0] cbe_in,
    input wire logic pin_in,
    output logic par_out,
    output logic par_oe_out,
    output logic perr_out
);

    logic rx_q;
    logic rx_par;
    wire even_par = ^{ad_in, cbe_in};
    wire pci_tx = tx_phase_in & ~gfx_txn_in & enable_in;
    wire pci_rx = rx_phase_in & ~gfx_txn_in & enable_in;

    // ----------------------------------------------------------
    // Parity lags its data phase by one clock
    // ----------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            par_out <= 1'b0;
            par_oe_out <= 1'b0;
            perr_out <= 1'b0;
            rx_q <= 1'b0;
            rx_par <= 1'b0;
        end else if (ce_in) begin
            par_out <= even_par;
            par_oe_out <= pci_tx;
            rx_q <= pci_rx;
            rx_par <= even_par;
            perr_out <= rx_q & pci_rx_chk(pin_in, rx_par);
        end
    end

    function automatic logic pci_rx_chk(input logic pin, input logic exp);
        pci_rx_chk = pin ^ exp;
    endfunction

endmodule // parity_unit

`default_nettype wire

// ---- core/strap_capture.sv ----
`timescale 1ns/1ps
`default_nettype none

module strap_capture (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic power_good_in,
    input wire logic bus_strap_in,
    input wire logic detect_pin_in,
    output strap_cfg_pkg::strap_t straps_out
);

    typedef enum logic {ST_WAIT, ST_HELD} cap_state_t;

    cap_state_t state;
    logic pg_q;
    wire pg_rise = power_good_in & ~pg_q;

    // ----------------------------------------------------------
    // Capture on power-good rise only
    // ----------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state <= ST_WAIT;
            // Power good high through reset is no edge, so no second capture
            pg_q <= 1'b1;
            straps_out <= '0;
        end else if (ce_in) begin
            pg_q <= power_good_in;
            unique case (state)
                ST_WAIT: begin
                    if (pg_rise) begin
                        state <= ST_HELD;
                        straps_out <= {1'b1, bus_strap_in, detect_pin_in};
                    end
                end
                // Held until power-good drops, so no resample glitch
                ST_HELD: begin
                    if (!power_good_in) begin
                        state <= ST_WAIT;
                    end
                end
            endcase
        end
    end

endmodule // strap_capture

`default_nettype wire

// ---- core/strap_cfg_pkg.sv ----
package strap_cfg_pkg;

    // ------------------------------------------------------------
    // Configuration space layout
    // ------------------------------------------------------------
    localparam logic [4:0] DEV_HOST = 5'h00;
    localparam logic [4:0] DEV_GFX_BRIDGE = 5'h01;
    localparam logic [7:0] OFS_GC = 8'h52;
    localparam logic [7:0] OFS_HUB_CFG = 8'hC6;
    localparam logic [7:0] OFS_CAP_ID = 8'hE4;
    localparam int RSVD_COUNT = 10;
    // aperture_base, graphics_port_misc, graphics_cap_id,
    // graphics_port_status, graphics_port_command,
    // graphics_port_control, aperture_size, aperture_table_base,
    // mtt_control, low_priority_timer
    localparam logic [RSVD_COUNT-1:0][7:0] RSVD_OFS = {
        8'h10, 8'h51, 8'hA0, 8'hA4, 8'hA8,
        8'hB0, 8'hB4, 8'hB8, 8'hBC, 8'hBD
    };

    // ------------------------------------------------------------
    // Field positions and values after reset
    // ------------------------------------------------------------
    localparam int GC_IGD_BIT = 3;
    localparam logic GC_IGD_APPLIES = 1'b0;
    localparam logic [7:0] GC_RESET = 8'h00;
    localparam int HUB_BUSFREQ_BIT = 12;
    localparam int HUB_VIDEO_BIT = 3;
    localparam logic [15:0] HUB_RESET = 16'h0C01;
    localparam logic [15:0] HUB_WR_MASK = 16'hEFF7;
    localparam logic [31:0] CAP_VALUE = 32'h0105A009;
    localparam logic [7:0] CAP_NEXT_PTR = 8'hA0;
    localparam logic [7:0] CAP_END_PTR = 8'h00;
    localparam logic STRAP_BUS_400 = 1'b0;
    localparam logic STRAP_VIDEO_DIGITAL = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {RATE_400, RATE_533} bus_rate_t;

    typedef struct packed {
        logic wr;
        logic [4:0] dev;
        logic [2:0] func;
        logic [7:0] ofs;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic ack;
        logic fwd_hub;
        logic hit;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic valid;
        logic bus_freq;
        logic video_sel;
    } strap_t;

endpackage

// ---- core/variant_strap_config_regs.sv ----
// Function
// - Low-cost variant runs the processor bus at 400 MHz from 100 MHz only.
// - Other variant runs 400 MHz or 533 MHz, the latter from 133 MHz.
// - Bus frequency strap sampled 0 selects 400 MHz bus rate.
// - Detect strap pin has internal pull-up so undriven reads high.
// - Detect strap pulled low sets video-select bit to digital video.
// - Digital video pins are dedicated, never shared with graphics-port bus.
// - Shared parity pin ignored in graphics-port cycles, PCI parity otherwise.
// - Removed graphics-port and aperture offsets are reserved, nothing behind.
// - Graphics disable control disables Device 1, forwards its cycles to hub.
// - Then capability next pointer reads 00h and ignores writes.
// - Graphics disable bit 0 means internal graphics enabled, reset value.
// - Bus strap latched at power-good rise into read-only hub bit 12.
// - Video-mode bit reads 0 for strap low, 1 for strap high.
`timescale 1ns/1ps
`default_nettype none

module variant_strap_config_regs #(
    parameter bit LOW_COST = 1'b1
) (
    // Clock, reset, enable
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    input wire logic CE_IN,
    // Power good and straps
    input wire logic POWER_GOOD_IN,
    input wire logic BUS_FREQ_STRAP_IN,
    // Shared parity pin
    input wire logic SHARED_PARITY_PIN_IN,
    output logic SHARED_PARITY_PIN_OUT,
    output logic SHARED_PARITY_PIN_OE_OUT,
    output logic PARITY_PULLUP_EN_OUT,
    // PCI-style transaction side
    input wire logic PCI_TX_PHASE_IN,
    input wire logic PCI_RX_PHASE_IN,
    input wire logic GFX_TXN_IN,
    input wire logic [31:0] PCI_AD_IN,
    input wire logic [3:0] PCI_CBE_IN,
    output logic PARITY_ERR_OUT,
    // Configuration cycles
    input wire logic CFG_REQ_VALID_IN,
    input wire strap_cfg_pkg::cfg_req_t CFG_REQ_IN,
    output strap_cfg_pkg::cfg_rsp_t CFG_RSP_OUT,
    // Mode outputs
    output logic BUS_RATE_533_OUT,
    output logic BUS_RATE_UNSUPPORTED_OUT,
    output logic STRAPS_VALID_OUT,
    output logic DVO_PORT_EN_OUT,
    output logic GFX_PORT_EN_OUT,
    output logic DEV1_DISABLED_OUT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    strap_cfg_pkg::strap_t straps;
    strap_cfg_pkg::cfg_rsp_t next_rsp;
    strap_cfg_pkg::bus_rate_t next_rate;
    logic [7:0] gc;
    logic [15:0] hub_rw;
    logic [15:0] next_hub_rw;
    localparam int RSVD_LAST = strap_cfg_pkg::RSVD_COUNT - 1;
    logic [RSVD_LAST:0] rsvd_match;
    logic par_bit;
    logic par_oe;
    logic perr;

    // ------------------------------------------------------------
    // Strap sampling
    // ------------------------------------------------------------
    // Power good is taken as synchronous to the system clock, so the
    // edge detector inside sits directly on the pin with no extra flops.
    // one capture per assertion
    strap_capture u_straps (
        .clk_in(CLK_SYS_IN),
        .resetn_in(RESETN_IN),
        .ce_in(CE_IN),
        .power_good_in(POWER_GOOD_IN),
        .bus_strap_in(BUS_FREQ_STRAP_IN),
        .detect_pin_in(SHARED_PARITY_PIN_IN),
        .straps_out(straps)
    );

    // ------------------------------------------------------------
    // Bus rate selection
    // ------------------------------------------------------------
    wire strap_is_400 = straps.bus_freq == strap_cfg_pkg::STRAP_BUS_400;

    // Low-cost parts keep 400 on a fast strap; the flag below tells software
    // strap 0 gives 400
    always_comb begin
        next_rate = strap_cfg_pkg::RATE_400;
        if (!LOW_COST && !strap_is_400) begin
            next_rate = strap_cfg_pkg::RATE_533;
        end
    end

    // flag a board strap that cannot boot
    wire unsupported = LOW_COST & straps.valid & ~strap_is_400;

    // ------------------------------------------------------------
    // Video mode and device 1 state
    // ------------------------------------------------------------
    // Before any capture the video bit reads 1, the level of the pull-up
    // video bit follows the sampled strap
    wire video_bit = straps.valid ? straps.video_sel : 1'b1;

    wire video_digital = video_bit == strap_cfg_pkg::STRAP_VIDEO_DIGITAL;

    wire dev1_off = gc[strap_cfg_pkg::GC_IGD_BIT] == strap_cfg_pkg::GC_IGD_APPLIES;

    // ------------------------------------------------------------
    // Next values of the mode outputs
    // ------------------------------------------------------------
    // Rate follows the strap only where 533 is supported; the video
    // port stays off until a capture, so pads never act on an unread strap.
    wire next_rate_533 = next_rate == strap_cfg_pkg::RATE_533;
    wire next_dvo_en = straps.valid & video_digital;

    // ------------------------------------------------------------
    // Configuration address decode
    // ------------------------------------------------------------
    // Offset bits 1:0 are ignored; byte enables pick the lanes of the dword
    wire [5:0] req_dw = CFG_REQ_IN.ofs[7:2];
    wire req_take = CE_IN & CFG_REQ_VALID_IN;
    wire to_dev0 = CFG_REQ_IN.dev == strap_cfg_pkg::DEV_HOST;
    wire to_dev1 = CFG_REQ_IN.dev == strap_cfg_pkg::DEV_GFX_BRIDGE;
    wire hit_gc = req_dw == strap_cfg_pkg::OFS_GC[7:2];
    wire hit_hub = req_dw == strap_cfg_pkg::OFS_HUB_CFG[7:2];
    wire hit_cap = req_dw == strap_cfg_pkg::OFS_CAP_ID[7:2];

    // Dword 50h is shared: byte 51h is reserved, byte 52h is graphics control
    // reserved offsets decode to nothing
    genvar gi;
    generate
        for (gi = 0; gi <= RSVD_LAST; gi++) begin : g_rsvd
            assign rsvd_match[gi] = req_dw == strap_cfg_pkg::RSVD_OFS[gi][7:2];
        end
    endgenerate

    wire hit_rsvd = |rsvd_match;
    wire dev0_hit = to_dev0 & (hit_gc | hit_hub | hit_cap | hit_rsvd);

    // device 1 cycles fall through to hub
    wire fwd = to_dev1 & dev1_off;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // next pointer ends the capability list
    wire [7:0] cap_ptr = dev1_off ? strap_cfg_pkg::CAP_END_PTR
                                  : strap_cfg_pkg::CAP_NEXT_PTR;

    wire [31:0] cap_rd = {
        strap_cfg_pkg::CAP_VALUE[31:16],
        cap_ptr,
        strap_cfg_pkg::CAP_VALUE[7:0]
    };

    // Read-only bits come from the straps, never from hub_rw, so writes cannot fake them
    // bit 12 is read-only strap value
    // bit 3 is read-only video mode
    wire [15:0] hub_rd = {
        hub_rw[15:13],
        straps.bus_freq,
        hub_rw[11:4],
        video_bit,
        hub_rw[2:0]
    };

    // Bytes 50h, 51h and C4h-C5h belong elsewhere and read zero here
    wire [31:0] gc_rd = {8'h00, gc, 16'h0000};
    wire [31:0] hub_dw_rd = {hub_rd, 16'h0000};

    wire [31:0] dev0_rd = hit_gc ? gc_rd
                        : hit_hub ? hub_dw_rd
                        : hit_cap ? cap_rd
                        : 32'h0000_0000;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // Only the hub word carries writable bits; graphics control,
    // capability and reserved words drop every write.
    wire [15:0] hub_be = {{8{CFG_REQ_IN.be[3]}}, {8{CFG_REQ_IN.be[2]}}};
    wire [15:0] hub_wmask = hub_be & strap_cfg_pkg::HUB_WR_MASK;
    wire hub_wr = req_take & CFG_REQ_IN.wr & to_dev0 & hit_hub;
    // Bytes C4h-C5h live elsewhere, so only the upper two lanes land here
    wire [15:0] hub_wdata = CFG_REQ_IN.wdata[31:16];

    always_comb begin
        next_hub_rw = hub_rw;
        if (hub_wr) begin
            next_hub_rw = (hub_rw & ~hub_wmask)
                        | (hub_wdata & hub_wmask);
        end
    end

    // ------------------------------------------------------------
    // Response
    // ------------------------------------------------------------
    // Devices above 1 get no answer here; the hub side owns them.
    // Writes answer with zero data, so a stray capture of rdata is harmless.
    always_comb begin
        next_rsp = '0;
        if (req_take) begin
            next_rsp.ack = to_dev0;
            next_rsp.fwd_hub = fwd;
            next_rsp.hit = dev0_hit;
            if (to_dev0 && !CFG_REQ_IN.wr) begin
                next_rsp.rdata = dev0_rd;
            end
        end
    end

    // ------------------------------------------------------------
    // Shared parity pin
    // ------------------------------------------------------------
    // Parity stays off the pin until straps are captured, so the
    // first detect strap capture is never fought by our own driver.
    // PCI parity only, ignored for graphics cycles
    parity_unit u_parity (
        .clk_in(CLK_SYS_IN),
        .resetn_in(RESETN_IN),
        .ce_in(CE_IN),
        .enable_in(straps.valid),
        .tx_phase_in(PCI_TX_PHASE_IN),
        .rx_phase_in(PCI_RX_PHASE_IN),
        .gfx_txn_in(GFX_TXN_IN),
        .ad_in(PCI_AD_IN),
        .cbe_in(PCI_CBE_IN),
        .pin_in(SHARED_PARITY_PIN_IN),
        .par_out(par_bit),
        .par_oe_out(par_oe),
        .perr_out(perr)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            // Graphics control is read-only, so gc never moves after reset
            // internal graphics enabled at reset
            gc <= strap_cfg_pkg::GC_RESET;
            hub_rw <= strap_cfg_pkg::HUB_RESET;
            CFG_RSP_OUT <= '0;
        end else if (CE_IN) begin
            hub_rw <= next_hub_rw;
            CFG_RSP_OUT <= next_rsp;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            BUS_RATE_533_OUT <= 1'b0;
            BUS_RATE_UNSUPPORTED_OUT <= 1'b0;
            STRAPS_VALID_OUT <= 1'b0;
            DEV1_DISABLED_OUT <= 1'b1;
        end else if (CE_IN) begin
            BUS_RATE_533_OUT <= next_rate_533;
            BUS_RATE_UNSUPPORTED_OUT <= unsupported;
            STRAPS_VALID_OUT <= straps.valid;
            DEV1_DISABLED_OUT <= dev1_off;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            PARITY_PULLUP_EN_OUT <= 1'b1;
            DVO_PORT_EN_OUT <= 1'b0;
            GFX_PORT_EN_OUT <= 1'b0;
        end else if (CE_IN) begin
            // Pull-up stays on while we drive parity; our driver overrides it,
            // and the detect strap can never float between uses.
            PARITY_PULLUP_EN_OUT <= 1'b1;
            // dedicated video pins, no graphics bus
            DVO_PORT_EN_OUT <= next_dvo_en;
            GFX_PORT_EN_OUT <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            SHARED_PARITY_PIN_OUT <= 1'b0;
            SHARED_PARITY_PIN_OE_OUT <= 1'b0;
            PARITY_ERR_OUT <= 1'b0;
        end else if (CE_IN) begin
            SHARED_PARITY_PIN_OUT <= par_bit;
            SHARED_PARITY_PIN_OE_OUT <= par_oe;
            PARITY_ERR_OUT <= perr;
        end
    end

endmodule // variant_strap_config_regs

`default_nettype wire

// ---- dv/strap_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module strap_board_model #(
    parameter bit LOW_COST = 1'h1
) (
    // Clock
    input wire logic clk_in,
    // Board build and bench drive
    input wire logic dvo_board_in,
    input wire logic fast_cpu_in,
    input wire logic ext_en_in,
    input wire logic ext_val_in,
    // Device pin side
    input wire logic pullup_en_in,
    input wire logic pin_oe_in,
    input wire logic pin_drv_in,
    output logic pin_out,
    output logic bus_strap_out
);
    // Undriven pin without pull-up wanders, so it never reads as a clean level
    logic wander = 1'h0;

    always_ff @(posedge clk_in) begin
        wander <= ~wander;
    end

    assign bus_strap_out = fast_cpu_in & ~LOW_COST;
    assign pin_out = pin_oe_in ? pin_drv_in : ext_en_in ? ext_val_in :
                     dvo_board_in ? 1'h0 : pullup_en_in ? 1'h1 : wander;
endmodule // strap_board_model

`default_nettype wire

// ---- dv/strap_cfg_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module strap_cfg_props #(
    parameter bit LOW_COST = 1'h1
) (
    // Clock, reset, enable
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    input wire logic CE_IN,
    // Straps and parity pin
    input wire logic POWER_GOOD_IN,
    input wire logic BUS_FREQ_STRAP_IN,
    input wire logic SHARED_PARITY_PIN_IN,
    input wire logic SHARED_PARITY_PIN_OUT,
    input wire logic SHARED_PARITY_PIN_OE_OUT,
    input wire logic PARITY_PULLUP_EN_OUT,
    // Transactions
    input wire logic PCI_TX_PHASE_IN,
    input wire logic GFX_TXN_IN,
    input wire logic [31:0] PCI_AD_IN,
    input wire logic [3:0] PCI_CBE_IN,
    input wire logic CFG_REQ_VALID_IN,
    input wire strap_cfg_pkg::cfg_req_t CFG_REQ_IN,
    input wire strap_cfg_pkg::cfg_rsp_t CFG_RSP_OUT,
    // Mode outputs
    input wire logic BUS_RATE_533_OUT,
    input wire logic STRAPS_VALID_OUT,
    input wire logic DVO_PORT_EN_OUT,
    input wire logic GFX_PORT_EN_OUT,
    input wire logic DEV1_DISABLED_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    // ----
    // Helper logic
    // ----
    logic pg_d;
    logic take;
    logic bus_q;
    logic det_q;
    logic cap_bus;
    logic cap_det;
    wire logic ad_par = ^{PCI_AD_IN, PCI_CBE_IN};
    wire logic rd = CE_IN && CFG_REQ_VALID_IN && !CFG_REQ_IN.wr && CFG_REQ_IN.dev == 5'h00;
    wire logic [5:0] dw = CFG_REQ_IN.ofs[7:2];

    // Dword 50h also holds the graphics control byte, so it is not empty
    function automatic logic is_rsvd(input logic [5:0] d);
        is_rsvd = 1'h0;
        for (int i = 0; i < strap_cfg_pkg::RSVD_COUNT; i++) begin
            is_rsvd |= (strap_cfg_pkg::RSVD_OFS[i][7:2] == d) && (d != 6'h14);
        end
    endfunction

    // Captured values are copied one cycle late, in step with the registered outputs
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            pg_d <= 1'h1;
            take <= 1'h0;
        end else if (CE_IN) begin
            pg_d <= POWER_GOOD_IN;
            take <= POWER_GOOD_IN && !pg_d;
            bus_q <= BUS_FREQ_STRAP_IN;
            det_q <= SHARED_PARITY_PIN_IN;
            if (take) begin
                cap_bus <= bus_q;
                cap_det <= det_q;
            end
        end
    end

    // ----
    // Assertions
    // ----
    rate_sel_a:
        assert property (STRAPS_VALID_OUT |-> BUS_RATE_533_OUT == (cap_bus && !LOW_COST))
        else $error("bus rate output disagrees with strap");
    dvo_mode_a:
        assert property (STRAPS_VALID_OUT |-> DVO_PORT_EN_OUT == !cap_det)
        else $error("video port enable disagrees with detect strap");
    straps_hold_a:
        assert property (STRAPS_VALID_OUT && $past(STRAPS_VALID_OUT) && !$past(take) |->
            $stable(DVO_PORT_EN_OUT) && $stable(BUS_RATE_533_OUT))
        else $error("strap outputs moved while held");
    fixed_pins_a:
        assert property (PARITY_PULLUP_EN_OUT && !GFX_PORT_EN_OUT && DEV1_DISABLED_OUT)
        else $error("fixed mode output wrong");
    dev1_fwd_a:
        assert property (CE_IN && CFG_REQ_VALID_IN && CFG_REQ_IN.dev == 5'h01 |=>
            CFG_RSP_OUT.fwd_hub && !CFG_RSP_OUT.ack)
        else $error("device 1 cycle not forwarded");
    cap_end_a:
        assert property (rd && dw == 6'h39 |=> CFG_RSP_OUT.hit && CFG_RSP_OUT.rdata[15:8] == 8'h00)
        else $error("capability pointer not ended");
    gc_zero_a:
        assert property (rd && dw == 6'h14 |=> CFG_RSP_OUT.rdata[23:16] == 8'h00)
        else $error("graphics control not zero");
    rsvd_empty_a:
        assert property (rd && is_rsvd(dw) |=> CFG_RSP_OUT.hit && CFG_RSP_OUT.rdata == 32'h0)
        else $error("reserved offset returned data");
    hub_strap_a:
        assert property (rd && dw == 6'h31 && STRAPS_VALID_OUT |=>
            CFG_RSP_OUT.rdata[28] == cap_bus && CFG_RSP_OUT.rdata[19] == cap_det)
        else $error("hub strap bits wrong");
    par_tx_a:
        assert property (CE_IN && PCI_TX_PHASE_IN && !GFX_TXN_IN && STRAPS_VALID_OUT &&
            POWER_GOOD_IN |-> ##2 SHARED_PARITY_PIN_OE_OUT &&
            SHARED_PARITY_PIN_OUT == $past(ad_par, 2))
        else $error("parity not driven correctly");
    gfx_mask_a:
        assert property ($past(GFX_TXN_IN, 2) |-> !SHARED_PARITY_PIN_OE_OUT)
        else $error("parity driven in graphics cycle");
endmodule // strap_cfg_props

bind variant_strap_config_regs strap_cfg_props #(.LOW_COST(LOW_COST)) strap_cfg_props_inst (.*);

`default_nettype wire

// ---- dv/variant_strap_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module variant_strap_config_regs_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic pg = 1'h0;
    logic tx = 1'h0, rx = 1'h0, gfx = 1'h0, vld = 1'h0;
    logic [31:0] ad = 32'h0;
    logic [3:0] cbe = 4'h0;
    strap_cfg_pkg::cfg_req_t req = '0;
    strap_cfg_pkg::cfg_rsp_t rsp;
    logic dvo = 1'h0, fast = 1'h0, ext_en = 1'h0, ext_val = 1'h0;
    logic pin, strap, par_o, par_oe, pull, perr, r533, unsup, sval, dvo_en, gfx_en, dev1;
    logic det;
    logic [15:0] hub_w = 16'h0C01;
    integer seed = 32'h096F;
    int n_mismatch = 0;
    int num_checks = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    variant_strap_config_regs variant_strap_config_regs_inst (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce), .POWER_GOOD_IN(pg),
        .BUS_FREQ_STRAP_IN(strap), .SHARED_PARITY_PIN_IN(pin), .SHARED_PARITY_PIN_OUT(par_o),
        .SHARED_PARITY_PIN_OE_OUT(par_oe), .PARITY_PULLUP_EN_OUT(pull),
        .PCI_TX_PHASE_IN(tx), .PCI_RX_PHASE_IN(rx), .GFX_TXN_IN(gfx), .PCI_AD_IN(ad),
        .PCI_CBE_IN(cbe), .PARITY_ERR_OUT(perr), .CFG_REQ_VALID_IN(vld), .CFG_REQ_IN(req),
        .CFG_RSP_OUT(rsp), .BUS_RATE_533_OUT(r533), .BUS_RATE_UNSUPPORTED_OUT(unsup),
        .STRAPS_VALID_OUT(sval), .DVO_PORT_EN_OUT(dvo_en), .GFX_PORT_EN_OUT(gfx_en),
        .DEV1_DISABLED_OUT(dev1)
    );

    strap_board_model strap_board_model_inst (
        .clk_in(clk), .dvo_board_in(dvo), .fast_cpu_in(fast), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pullup_en_in(pull), .pin_oe_in(par_oe), .pin_drv_in(par_o),
        .pin_out(pin), .bus_strap_out(strap)
    );

    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Response is registered, so it is looked at just after the taking edge
    task automatic cfg(input logic wr, input logic [4:0] dev, input logic [7:0] o,
                       input logic [31:0] wd);
        @(posedge clk);
        vld <= 1'h1;
        req <= '{wr, dev, 3'h0, o, 4'hF, wd};
        @(posedge clk);
        vld <= 1'h0;
        #1;
    endtask

    // Bus strap bit stays 0: the low-cost board never straps the fast rate
    function automatic logic [31:0] exp_rd(input logic [7:0] o);
        logic [15:0] hub;
        hub = (hub_w & strap_cfg_pkg::HUB_WR_MASK) | {12'h0, det, 3'h0};
        case (o[7:2])
            6'h31: exp_rd = {hub, 16'h0};
            6'h39: exp_rd = 32'h0105_0009;
            default: exp_rd = 32'h0;
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        logic [7:0] o;
        logic [31:0] a;
        logic bad, seen;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        #1;
        check({dev1, gfx_en, sval, pull, rsp}, {4'h9, 35'h0});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pg <= 1'h0;
            dvo <= (i < 2) ? 1'(i) : 1'($random(seed));
            fast <= 1'($random(seed));
            @(posedge clk);
            pg <= 1'h1;
            repeat (3) @(posedge clk);
            #1;
            det = ~dvo;
            check({sval, dvo_en, r533, unsup}, {1'h1, dvo, 2'h0});
            a = $random(seed);
            cfg(1'h1, 5'h00, 8'hC4, a);
            check(rsp, {3'h5, 32'h0});
            hub_w = a[31:16];
            dvo <= ~dvo;
            cfg(1'h0, 5'h00, 8'hC6, 32'h0);
            check(rsp, {3'h5, exp_rd(8'hC4)});
        end
        for (int i = 0; i < strap_cfg_pkg::RSVD_COUNT + 2; i++) begin
            o = (i < strap_cfg_pkg::RSVD_COUNT) ? strap_cfg_pkg::RSVD_OFS[i] :
                (i == strap_cfg_pkg::RSVD_COUNT) ? 8'h50 : 8'hE4;
            cfg(1'h1, 5'h00, o, $random(seed));
            cfg(1'h0, 5'h00, o, 32'h0);
            check(rsp, {3'h5, exp_rd(o)});
        end
        for (int d = 0; d < 3; d++) begin
            cfg(1'h0, 5'(d), 8'h40, 32'h0);
            check(rsp, {(d == 0) ? 3'h4 : (d == 1) ? 3'h2 : 3'h0, 32'h0});
        end
        for (int i = 0; i < 6; i++) begin
            a = $random(seed);
            @(posedge clk);
            tx <= 1'h1;
            gfx <= i[0];
            ad <= a;
            cbe <= a[7:4];
            @(posedge clk);
            tx <= 1'h0;
            @(posedge clk);
            #1;
            check({par_oe, par_o & ~gfx}, {~gfx, ~gfx & ^{ad, cbe}});
            bad = (i < 4) ? i[1] : 1'($random(seed));
            a = $random(seed);
            @(posedge clk);
            rx <= 1'h1;
            ad <= a;
            ext_en <= 1'h1;
            ext_val <= ^{a, cbe} ^ bad;
            // Pin stays driven one edge past the phase: that is where it is compared
            @(posedge clk);
            rx <= 1'h0;
            @(posedge clk);
            ext_en <= 1'h0;
            @(posedge clk);
            #1;
            seen = perr;
            @(posedge clk);
            #1;
            check(seen | perr, bad & ~gfx);
        end
        // Clock enable low: a device 1 request must not be taken
        @(posedge clk);
        ce <= 1'h0;
        vld <= 1'h1;
        req <= '{1'h0, 5'h01, 3'h0, 8'h40, 4'hF, 32'h0};
        @(posedge clk);
        ce <= 1'h1;
        vld <= 1'h0;
        #1;
        check(rsp, 35'h0);
        summarize();
    end
endmodule // variant_strap_config_regs_tb

`default_nettype wire
